// File: rtl/sfg_consts.vh
/*
 constants of the serial flash bus front end and write guard.
 assumes inclusion by sfg_top.v only.
*/
// Summary of operation
// - deselected: output released, internal cycle continues
// - first instruction only after select falls
// - output bits change on falling clock
// - input bits sampled on rising clock
// - clock idling low or high both work
// - pause starts now or next falling edge
// - pause ends now or next falling edge
// - paused: output released, clock and input ignored
// - pause keeps partial instruction and data
// - guard pin active low, locks status only while lock bit set
// - in reset nothing is recognised
// - write instructions refused until delay elapses
// - enable latch clear after power-up
// - writes need enable latch set first
// - completion clears enable latch
// - protect bits make regions read-only
// - power-down accepts only release instruction
// - lock bit plus low guard refuses status write
// - enable latch bit1, busy bit0
// - first byte after select is opcode
// - busy: only status read accepted
`ifndef SFG_CONSTS_VH
`define SFG_CONSTS_VH
// ==========================================
// instruction codes
`define SFG_OP_WRSR 8'h01
`define SFG_OP_PP 8'h02
`define SFG_OP_READ 8'h03
`define SFG_OP_WRDI 8'h04
`define SFG_OP_RDSR 8'h05
`define SFG_OP_WREN 8'h06
`define SFG_OP_SE 8'hD8
`define SFG_OP_CE 8'hC7
`define SFG_OP_PD 8'hB9
`define SFG_OP_RPD 8'hAB
// ==========================================
// status byte fields
`define SFG_ST_BUSY 0
`define SFG_ST_WEL 1
`define SFG_ST_BP_LO 2
`define SFG_ST_BP_HI 4
`define SFG_ST_LOCK 7
`define SFG_BP_RST 3'h0
`define SFG_LOCK_RST 1'h0
// ==========================================
// bus registers
`define SFG_REG_CTRL 2'h0
`define SFG_REG_STAT 2'h1
`define SFG_REG_LAST 2'h2
`define SFG_CTRL_TOP 0
`define SFG_CTRL_RST 1'h0
// ==========================================
// timing
`define SFG_CLK_HZ 25000000
`define SFG_PUW_NS 1000000
`define SFG_PUW_CYC ((`SFG_PUW_NS / 1000) * (`SFG_CLK_HZ / 1000000))
`endif

// File: rtl/sfg_top.v
/*
 serial flash bus front end with write guard: spi slave, pause,
 instruction gating, status byte and a wishbone register slave.
 assumes an array back end that executes op_req_o and answers op_done_i,
 and returns read bytes within two clocks of rd_req_o.
*/
`timescale 1ns/100ps
`include "sfg_consts.vh"
module sfg_top #(
	parameter PUW_CYC = `SFG_PUW_CYC
) (
	input wire clk_i, // 25 mhz
	input wire rst_i, // supply-low reset, high
	input wire cs_n_i, // select pin, low active
	input wire sclk_i, // serial clock pin
	input wire serial_in_i, // serial data in pin
	input wire pause_n_i, // pause pin, low active
	input wire write_guard_n_i, // guard pin, low active
	output wire serial_out_o, // serial data out
	output wire serial_out_oe_n_o, // low while driving
	output reg op_req_o, // start internal cycle, pulse
	output reg [7:0] op_code_o, // opcode of the cycle
	output reg [23:0] op_addr_o, // address of cycle or read
	input wire op_done_i, // internal cycle finished, pulse
	output reg wr_stb_o, // page byte received, pulse
	output reg [7:0] wr_byte_o, // page byte
	output reg rd_req_o, // fetch byte at op_addr_o, pulse
	input wire [7:0] rd_data_i, // fetched byte
	input wire wb_cyc_i, // wishbone cycle
	input wire wb_stb_i, // wishbone strobe
	input wire wb_we_i, // wishbone write
	input wire [3:0] wb_adr_i, // wishbone byte address
	input wire [3:0] wb_sel_i, // wishbone byte lanes
	input wire [31:0] wb_dat_i, // wishbone write data
	output reg [31:0] wb_dat_o, // wishbone read data
	output reg wb_ack_o // wishbone ack
);
	localparam S_IDLE = 6'h01;
	localparam S_CMD = 6'h02;
	localparam S_ADDR = 6'h04;
	localparam S_DATA = 6'h08;
	localparam S_OUT = 6'h10;
	localparam S_SKIP = 6'h20;

	// ==========================================
	// protection map
	function [19:0] prot_len;
		input [2:0] bp;
		begin
			case (bp)
				3'h1: prot_len = 20'h01000;
				3'h2: prot_len = 20'h02000;
				3'h3: prot_len = 20'h04000;
				3'h4: prot_len = 20'h08000;
				3'h5: prot_len = 20'h10000;
				3'h6: prot_len = 20'h40000;
				3'h7: prot_len = 20'h80000;
				default: prot_len = 20'h00000;
			endcase
		end
	endfunction

	function is_prot;
		input [23:0] a;
		input [2:0] bp;
		input top;
		begin
			if (top)
				is_prot = ({1'b0, a[18:0]} >= (20'h80000 - prot_len(bp))) && (bp != 3'h0);
			else
				is_prot = {1'b0, a[18:0]} < prot_len(bp);
		end
	endfunction

	// ==========================================
	// pin synchronisers
	reg [4:0] sync1_q;
	reg [4:0] sync2_q;
	reg cs_p_q;
	reg sclk_p_q;
	wire cs_s = sync2_q[0];
	wire sclk_s = sync2_q[1];
	wire si_s = sync2_q[2];
	wire pause_s = sync2_q[3];
	wire guard_s = sync2_q[4];
	always @(posedge clk_i)
	begin
		sync1_q <= {write_guard_n_i, pause_n_i, serial_in_i, sclk_i, cs_n_i};
		sync2_q <= sync1_q;
	end

	// ==========================================
	// state
	reg [5:0] st_q;
	reg [4:0] cnt_q;
	reg [7:0] sh_q;
	reg [7:0] op_q;
	reg [23:0] addr_q;
	reg [7:0] data_q;
	reg ok_q;
	reg paused_q;
	reg [7:0] tx_q;
	reg [2:0] tx_cnt_q;
	reg drive_q;
	reg wel_q;
	reg busy_q;
	reg pd_q;
	reg lock_q;
	reg [2:0] bp_q;
	reg top_q;
	reg [7:0] last_q;
	reg [23:0] puw_q;
	wire puw_busy = (puw_q != 24'h0);
	wire sclk_fall_raw = sclk_p_q & ~sclk_s;
	// clock edges are invisible while paused
	wire sclk_rise = ~sclk_p_q & sclk_s & ~paused_q;
	wire sclk_fall = sclk_fall_raw & ~paused_q;
	wire cs_fall = cs_p_q & ~cs_s;
	wire cs_rise = ~cs_p_q & cs_s;
	wire [7:0] sh_in = {sh_q[6:0], si_s};
	wire [7:0] status = {lock_q, 2'b00, bp_q, wel_q, busy_q};
	wire wr_ok = wel_q & ~puw_busy;
	wire guard_lock = lock_q & ~guard_s;

	// output released when deselected or paused
	assign serial_out_o = tx_q[7];
	assign serial_out_oe_n_o = ~(drive_q & ~cs_s & ~paused_q);

	// ==========================================
	// power-up write delay
	always @(posedge clk_i)
	begin
		if (rst_i)
			puw_q <= PUW_CYC[23:0];
		else if (puw_busy)
			puw_q <= puw_q - 24'h1;
	end

	// ==========================================
	// pause: follows the pin only with clock low or at its falling edge; deselect clears it at once
	always @(posedge clk_i)
	begin
		if (rst_i || cs_s)
			paused_q <= 1'b0;
		else if ((pause_s == paused_q) && (~sclk_s || sclk_fall_raw))
			paused_q <= ~pause_s;
	end

	// ==========================================
	// serial engine
	always @(posedge clk_i)
	begin
		op_req_o <= 1'b0;
		wr_stb_o <= 1'b0;
		rd_req_o <= 1'b0;
		if (rst_i)
		begin
			// nothing recognised and write disabled in reset
			st_q <= S_IDLE;
			cs_p_q <= 1'b0;
			sclk_p_q <= 1'b0;
			cnt_q <= 5'h0;
			sh_q <= 8'h00;
			op_q <= 8'h00;
			addr_q <= 24'h0;
			data_q <= 8'h00;
			ok_q <= 1'b0;
			tx_q <= 8'h00;
			tx_cnt_q <= 3'h0;
			drive_q <= 1'b0;
			wel_q <= 1'b0;
			busy_q <= 1'b0;
			pd_q <= 1'b0;
			lock_q <= `SFG_LOCK_RST;
			bp_q <= `SFG_BP_RST;
			last_q <= 8'h00;
			op_code_o <= 8'h00;
			op_addr_o <= 24'h0;
			wr_byte_o <= 8'h00;
		end
		else
		begin
			// cs_p_q starts low so a select held low from reset needs a new fall
			cs_p_q <= cs_s;
			sclk_p_q <= sclk_s;
			// completion clears the latch; a cycle keeps running while deselected
			if (op_done_i)
			begin
				busy_q <= 1'b0;
				wel_q <= 1'b0;
			end
			if (cs_rise)
			begin
				st_q <= S_IDLE;
				drive_q <= 1'b0;
				ok_q <= 1'b0;
				// incomplete instructions simply fall away
				if (ok_q)
				begin
					last_q <= op_q;
					case (op_q)
						`SFG_OP_WREN:
							if (!puw_busy)
								wel_q <= 1'b1;
						`SFG_OP_WRDI:
							wel_q <= 1'b0;
						`SFG_OP_WRSR:
							if (wr_ok && !guard_lock)
							begin
								lock_q <= data_q[`SFG_ST_LOCK];
								bp_q <= data_q[`SFG_ST_BP_HI:`SFG_ST_BP_LO];
								busy_q <= 1'b1;
								op_req_o <= 1'b1;
								op_code_o <= op_q;
							end
						`SFG_OP_PP, `SFG_OP_SE:
							if (wr_ok && !is_prot(addr_q, bp_q, top_q))
							begin
								busy_q <= 1'b1;
								op_req_o <= 1'b1;
								op_code_o <= op_q;
								op_addr_o <= addr_q;
							end
						`SFG_OP_CE:
							if (wr_ok && bp_q == 3'h0)
							begin
								busy_q <= 1'b1;
								op_req_o <= 1'b1;
								op_code_o <= op_q;
							end
						`SFG_OP_PD:
							pd_q <= 1'b1;
						`SFG_OP_RPD:
							pd_q <= 1'b0;
						default:
							last_q <= op_q;
					endcase
				end
			end
			else if (cs_fall && st_q == S_IDLE)
			begin
				st_q <= S_CMD;
				cnt_q <= 5'h0;
			end
			else if (sclk_rise && !cs_s)
			begin
				case (st_q)
					S_CMD:
					begin
						sh_q <= sh_in;
						cnt_q <= cnt_q + 5'h1;
						if (cnt_q == 5'h7)
						begin
							op_q <= sh_in; // msb first
							cnt_q <= 5'h0;
							if (pd_q && sh_in != `SFG_OP_RPD)
								st_q <= S_SKIP;
							else if (busy_q && sh_in != `SFG_OP_RDSR)
								st_q <= S_SKIP;
							else
							begin
								case (sh_in)
									`SFG_OP_READ, `SFG_OP_PP, `SFG_OP_SE:
										st_q <= S_ADDR;
									`SFG_OP_WRSR:
										st_q <= S_DATA;
									`SFG_OP_RDSR:
									begin
										st_q <= S_OUT;
										drive_q <= 1'b1;
									end
									`SFG_OP_WREN, `SFG_OP_WRDI, `SFG_OP_CE, `SFG_OP_PD, `SFG_OP_RPD:
									begin
										st_q <= S_SKIP;
										ok_q <= 1'b1;
									end
									default:
										st_q <= S_SKIP;
								endcase
							end
						end
					end
					S_ADDR:
					begin
						addr_q <= {addr_q[22:0], si_s};
						cnt_q <= cnt_q + 5'h1;
						if (cnt_q == 5'd23)
						begin
							cnt_q <= 5'h0;
							if (op_q == `SFG_OP_READ)
							begin
								// back end has until the next falling edge to answer
								rd_req_o <= 1'b1;
								op_addr_o <= {addr_q[22:0], si_s};
								st_q <= S_OUT;
								drive_q <= 1'b1;
							end
							else if (op_q == `SFG_OP_PP)
							begin
								op_addr_o <= {addr_q[22:0], si_s};
								st_q <= S_DATA;
								ok_q <= 1'b1;
							end
							else
							begin
								st_q <= S_SKIP;
								ok_q <= 1'b1;
							end
						end
					end
					S_DATA:
					begin
						sh_q <= sh_in;
						cnt_q <= {2'b00, cnt_q[2:0] + 3'h1};
						if (cnt_q[2:0] == 3'h7)
						begin
							if (op_q == `SFG_OP_WRSR)
							begin
								data_q <= sh_in;
								ok_q <= 1'b1;
								st_q <= S_SKIP;
							end
							else
							begin
								wr_byte_o <= sh_in;
								wr_stb_o <= 1'b1;
							end
						end
					end
					default:
						cnt_q <= cnt_q;
				endcase
			end
			// transmit side, one bit per falling edge
			if (cs_rise || st_q != S_OUT)
				tx_cnt_q <= 3'h0;
			else if (sclk_fall && !cs_s)
			begin
				tx_cnt_q <= tx_cnt_q + 3'h1;
				if (tx_cnt_q == 3'h0)
				begin
					if (op_q == `SFG_OP_READ)
						tx_q <= rd_data_i;
					else
						tx_q <= status;
				end
				else
					tx_q <= {tx_q[6:0], 1'b0};
				// next byte fetched early so it is ready at the boundary
				if (tx_cnt_q == 3'h7 && op_q == `SFG_OP_READ)
				begin
					op_addr_o <= op_addr_o + 24'h1;
					rd_req_o <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// wishbone slave, one wait state
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			top_q <= `SFG_CTRL_RST;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o)
			begin
				if (wb_we_i && wb_adr_i[3:2] == `SFG_REG_CTRL && wb_sel_i[0])
					top_q <= wb_dat_i[`SFG_CTRL_TOP];
				case (wb_adr_i[3:2])
					`SFG_REG_CTRL: wb_dat_o <= {31'h0, top_q};
					`SFG_REG_STAT: wb_dat_o <= {20'h0, puw_busy, paused_q, pd_q, ~cs_s, status};
					`SFG_REG_LAST: wb_dat_o <= {24'h0, last_q};
					default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // sfg_top

// File: tb/sfg_monitor.sv
/*
 port checker for sfg_top.
 assumes 25 mhz clk_i and pins much slower than it.
*/
`timescale 1ns/100ps
module sfg_monitor (
	input wire clk_i, // clock
	input wire rst_i, // reset
	input wire cs_n_i, // select
	input wire sclk_i, // serial clock
	input wire pause_n_i, // pause
	input wire serial_out_o, // data out
	input wire serial_out_oe_n_o, // out enable
	input wire op_req_o, // cycle start
	input wire [7:0] op_code_o, // cycle opcode
	input wire wr_stb_o, // page byte
	input wire wb_cyc_i, // cycle
	input wire wb_stb_i, // strobe
	input wire wb_ack_o // ack
);
	// ==========
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// six cycles leaves room for the pin synchronisers
	sequence s_pause;
		(!cs_n_i && !pause_n_i && !sclk_i) [*6];
	endsequence
	chk_desel_release: assert property (cs_n_i [*6] |-> serial_out_oe_n_o)
		else $error("output driven while deselected");
	chk_reset_quiet: assert property ($fell(rst_i) |-> serial_out_oe_n_o && !op_req_o && !wb_ack_o)
		else $error("activity right after reset");
	chk_pause_release: assert property (s_pause |-> serial_out_oe_n_o)
		else $error("output driven while paused");
	chk_out_falling: assert property (!serial_out_oe_n_o && $past(!serial_out_oe_n_o)
		&& $changed(serial_out_o) |-> !$past(sclk_i, 2))
		else $error("output changed after rising clock");
	chk_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	chk_req_pulse: assert property (op_req_o |=> !op_req_o)
		else $error("cycle start too long");
	chk_req_code: assert property (op_req_o |-> op_code_o inside {8'h01, 8'h02, 8'hD8, 8'hC7})
		else $error("cycle for a non write opcode");
	chk_req_desel: assert property (op_req_o |-> cs_n_i)
		else $error("cycle started while selected");
	chk_stb_pulse: assert property (wr_stb_o |=> !wr_stb_o)
		else $error("byte strobe too long");
endmodule // sfg_monitor
bind sfg_top sfg_monitor u_sfg_monitor (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
	.sclk_i(sclk_i), .pause_n_i(pause_n_i), .serial_out_o(serial_out_o),
	.serial_out_oe_n_o(serial_out_oe_n_o), .op_req_o(op_req_o), .op_code_o(op_code_o),
	.wr_stb_o(wr_stb_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// File: tb/sfg_spi_master.sv
/*
 spi master model.
 assumes 25 mhz clk_i; sclk period is 8 clocks, 320 ns.
*/
`timescale 1ns/100ps
module sfg_spi_master (
	input wire clk_i, // bench clock
	input wire miso_i, // resolved data line
	output logic cs_n_o, // select
	output logic sclk_o, // serial clock
	output logic mosi_o // data to device
);
	// ==========
	// transfer
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// keep leaves select low with clock low, for pausing
	task automatic xfer(input logic [39:0] tx, input int n, input bit m3, input bit keep,
		output logic [7:0] rx);
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		sclk_o <= m3;
		for (int i = n - 1; i >= 0; i--)
		begin
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
			mosi_o <= tx[i];
			repeat (4) @(posedge clk_i);
			rx = {rx[6:0], miso_i};
			sclk_o <= 1'b1;
		end
		repeat (4) @(posedge clk_i);
		sclk_o <= m3 & !keep;
		mosi_o <= ~mosi_o;
		repeat (4) @(posedge clk_i);
		cs_n_o <= !keep;
		repeat (8) @(posedge clk_i);
	endtask
endmodule // sfg_spi_master

// File: tb/sfg_top_test.sv
/*
 self-checking bench for sfg_top.
 assumes the back end is played by the bench: op_done pulses on demand.
*/
`timescale 1ns/100ps
module sfg_top_test;
	logic clk_i = 1'b0, rst_i = 1'b1, pause_n = 1'b1, guard_n = 1'b0, op_done = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rd;
	logic [7:0] rx, wbyte;
	wire cs_n, sclk, mosi, so, so_oe_n, op_req, wr_stb, ack;
	wire [7:0] op_code, wr_byte;
	wire [23:0] op_addr;
	wire [31:0] rdat;
	// released line shows the inverse, so a stale sample stands out
	wire miso = so_oe_n ? ~so : so;
	int err_total = 0, comparisons = 0, reqs = 0, nreq = 0;
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		if (op_req)
			reqs <= reqs + 1;
		if (wr_stb)
			wbyte <= wr_byte;
	end
	sfg_spi_master u_sfg_spi_master (.clk_i(clk_i), .miso_i(miso), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));
	sfg_top #(.PUW_CYC(200)) u_sfg_top (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
		.serial_in_i(mosi), .pause_n_i(pause_n), .write_guard_n_i(guard_n), .serial_out_o(so),
		.serial_out_oe_n_o(so_oe_n), .op_req_o(op_req), .op_code_o(op_code), .op_addr_o(op_addr),
		.op_done_i(op_done), .wr_stb_o(wr_stb), .wr_byte_o(wr_byte), .rd_req_o(), .rd_data_i(8'h00),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	// ==========
	// helpers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n == 50)
		begin
			err_total++;
			wrap_up();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic st(input logic [11:0] e);
		wb(1'b0, 4'h4, 32'h0, rd);
		chk("stat", {20'h0, e}, rd);
	endtask
	task automatic spi(input logic [39:0] tx, input int n, input bit m3 = 1'b0, input bit k = 1'b0);
		u_sfg_spi_master.xfer(tx, n, m3, k, rx);
	endtask
	task automatic done;
		@(posedge clk_i);
		op_done <= 1'b1;
		@(posedge clk_i);
		op_done <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic wrap_up;
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_puw;
		spi(40'h06, 8);
		st(12'h800);
		repeat (200) @(posedge clk_i);
		st(12'h000);
	endtask
	task automatic t_wel;
		spi(40'h03, 7);
		st(12'h000);
		spi(40'h06, 8, 1'b1);
		st(12'h002);
		spi(40'h0500, 16);
		chk("rdsr", 32'h02, {24'h0, rx});
		spi(40'h04, 8);
		st(12'h000);
	endtask
	task automatic t_pp;
		spi({8'h02, 24'h000123, 8'h5A}, 40);
		chk("reqs", nreq, reqs);
		spi(40'h06, 8);
		spi({8'h02, 24'h012345}, 32, 1'b0, 1'b1);
		pause_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		st(12'h502);
		spi(40'hFF, 8, 1'b0, 1'b1);
		pause_n <= 1'b1;
		spi(40'hA5, 8);
		nreq++;
		chk("byte", 32'hA5, wbyte);
		chk("reqs", nreq, reqs);
		chk("code", 32'h02, op_code);
		chk("addr", 32'h012345, op_addr);
		spi(40'h04, 8);
		st(12'h003);
		done();
		st(12'h000);
	endtask
	task automatic t_lock;
		spi(40'h06, 8);
		spi(40'h0184, 16);
		nreq++;
		chk("reqs", nreq, reqs);
		st(12'h087);
		done();
		spi(40'h06, 8);
		spi({8'h02, 24'h000010, 8'h11}, 40);
		spi(40'h0100, 16);
		chk("reqs", nreq, reqs);
		st(12'h086);
		guard_n <= 1'b1;
		spi(40'h0100, 16);
		nreq++;
		chk("reqs", nreq, reqs);
		done();
		st(12'h000);
	endtask
	task automatic t_pd;
		spi(40'hB9, 8);
		spi(40'h06, 8);
		st(12'h200);
		spi(40'hAB, 8);
		st(12'h000);
	endtask
	task automatic t_wb;
		wb(1'b0, 4'h0, 32'h0, rd);
		chk("ctrl", 32'h0, rd);
		wb(1'b1, 4'h0, 32'h1, rd);
		wb(1'b0, 4'h0, 32'h0, rd);
		chk("ctrl", 32'h1, rd);
		wb(1'b0, 4'hC, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_puw();
		t_wel();
		t_pp();
		t_lock();
		t_pd();
		t_wb();
		wrap_up();
	end
	// whole run needs about 2900 clocks
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
endmodule // sfg_top_test
